// *** logic/dsadc_ctrl.sv ***
// control and readout of a dual simultaneous-sampling 14-bit converter
`timescale 1ns/100ps
`default_nettype none
`include "dsadc_params.svh"

// Notes on behaviour
// - start falling edge holds both samples and starts both conversions together
// - first read gives input 1 of the chosen pair, second read input 2
// - busy falling marks end; both results readable from then on
// - conversion lasts at most 5.2 us fast mode, 10 us auto sleep
// - auto sleep mode sleeps after each conversion; fast mode stays powered
// - both track/holds return to tracking when the conversion ends
// - each result is one 14-bit word read with chip-select and read low
// - conversion timing comes from an internal clock, none from the host
// - repeated cycles reach 175 kHz when host keeps its timing windows
// - busy rises on start falling edge and stays high until conversion done
// - data driven from one clock after chip-select and read both go low until one clock after either rises
// - twos complement coding for bipolar build, straight binary for unipolar
module dsadc_ctrl #(
    parameter bit BIPOLAR = `DSADC_BIPOLAR_RST
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic conversion_start_n,
    input wire logic pair_select,
    input wire logic auto_sleep_mode,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire dsadc_pkg::dsadc_word_t pair_a_input_1,
    input wire dsadc_pkg::dsadc_word_t pair_a_input_2,
    input wire dsadc_pkg::dsadc_word_t pair_b_input_1,
    input wire dsadc_pkg::dsadc_word_t pair_b_input_2,
    output logic busy,
    output logic hold,
    output logic asleep,
    output dsadc_pkg::dsadc_word_t result_bus_o,
    output logic result_bus_oe
);
    import dsadc_pkg::*;

    localparam dsadc_cnt_t CONV_LOAD = dsadc_cnt_t'(`DSADC_CONV_HS_CYC - 3);
    localparam dsadc_cnt_t WAKE_LOAD = dsadc_cnt_t'(`DSADC_WAKE_CYC - 1);
    localparam int CONV_HS = `DSADC_CONV_HS_CYC;
    localparam int CONV_AS = `DSADC_CONV_AS_CYC;

    dsadc_ctrl_t s;
    dsadc_ctrl_t next_s;
    logic conv_fall;
    logic rd_act;
    logic flush;

    dsadc_stream_if #(.W(`DSADC_RES_W)) push_if ();
    dsadc_stream_if #(.W(`DSADC_RES_W)) pop_if ();

    // raw samples are offset binary; bipolar builds flip the top bit
    function automatic dsadc_word_t code(input dsadc_word_t raw);
        code = BIPOLAR ? {~raw[`DSADC_RES_W-1], raw[`DSADC_RES_W-2:0]} : raw;
    endfunction : code

    assign conv_fall = s.conv_prev && !conversion_start_n;
    assign rd_act = !cs_n && !rd_n;
    // a new start clears stale words so read order restarts at input 1
    assign flush = conv_fall && (s.st == DSADC_TRACK);
    // a word leaves the buffer when its read strobe ends
    assign pop_if.ready = s.rd_prev && !rd_act;

    dsadc_buf #(.W(`DSADC_RES_W)) u_buf (
        .mclk(mclk),
        .nrst(nrst),
        .flush(flush),
        .wr(push_if.snk),
        .rd(pop_if.src)
    );

    // sequencer: edges, internal conversion timing, result delivery, read port
    always_comb begin
        next_s = s;
        next_s.conv_prev = conversion_start_n;
        next_s.rd_prev = rd_act;
        push_if.valid = 1'b0;
        push_if.data = s.smp1;
        unique case (s.st)
            DSADC_TRACK: begin
                // starts during busy are ignored: only this state watches the edge
                if (conv_fall) begin
                    next_s.pair = pair_select;
                    next_s.smp1 = code(pair_select ? pair_b_input_1 : pair_a_input_1);
                    next_s.smp2 = code(pair_select ? pair_b_input_2 : pair_a_input_2);
                    next_s.busy = 1'b1;
                    next_s.hold = 1'b1;
                    if (s.asleep) begin
                        next_s.st = DSADC_WAKE;
                        next_s.cnt = WAKE_LOAD;
                    end else begin
                        next_s.st = DSADC_CONVERT;
                        next_s.cnt = CONV_LOAD;
                    end
                end
            end
            DSADC_WAKE: begin
                // power-up from sleep adds the extra time of the slow mode
                if (s.cnt == '0) begin
                    next_s.asleep = 1'b0;
                    next_s.st = DSADC_CONVERT;
                    next_s.cnt = CONV_LOAD;
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            DSADC_CONVERT: begin
                // internal timebase paces the conversion; no host clock needed
                if (s.cnt == '0) begin
                    next_s.st = DSADC_PUSH1;
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            DSADC_PUSH1: begin
                push_if.valid = 1'b1;
                push_if.data = s.smp1;
                if (push_if.ready) begin
                    next_s.st = DSADC_PUSH2;
                end
            end
            DSADC_PUSH2: begin
                push_if.valid = 1'b1;
                push_if.data = s.smp2;
                if (push_if.ready) begin
                    // busy drops only once both words sit in the buffer
                    next_s.st = DSADC_TRACK;
                    next_s.busy = 1'b0;
                    next_s.hold = 1'b0;
                    next_s.asleep = auto_sleep_mode;
                end
            end
        endcase
        // word latched at read start so it stays steady for the whole strobe
        if (rd_act && !s.rd_prev) begin
            next_s.dout = pop_if.valid ? pop_if.data : s.dout;
        end
        next_s.doe = rd_act;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.st <= DSADC_TRACK;
            s.conv_prev <= 1'b1;
            s.dout <= `DSADC_WORD_RST;
        end else begin
            s <= next_s;
        end
    end

    assign busy = s.busy;
    assign hold = s.hold;
    assign asleep = s.asleep;
    assign result_bus_o = s.dout;
    assign result_bus_oe = s.doe;

    // helper: length of each busy period and whether it included a wake-up
    logic [8:0] busy_cnt;
    logic woke;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt <= 9'h000;
            woke <= 1'b0;
        end else begin
            busy_cnt <= s.busy ? busy_cnt + 9'h001 : 9'h000;
            if (flush) begin
                woke <= s.asleep;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence conv_start_seq;
        (s.st == DSADC_TRACK) && conv_fall;
    endsequence

    sequence conv_end_seq;
        $fell(s.busy);
    endsequence

    AST_BUSY_RISE: assert property (conv_start_seq |=> s.busy && s.hold)
        else $error("busy or hold did not rise after start edge");
    AST_BUSY_LEN: assert property (conv_end_seq |-> busy_cnt == (woke ? CONV_AS : CONV_HS))
        else $error("conversion length wrong");
    AST_HOLD_BUSY: assert property (s.hold == s.busy)
        else $error("hold not aligned with busy");
    AST_READY_AT_END: assert property (conv_end_seq |-> pop_if.valid && u_buf.s.cnt == 2'h2)
        else $error("results not ready at end of busy");
    AST_FIRST_WORD: assert property (conv_end_seq |-> pop_if.data == s.smp1)
        else $error("first word is not input 1");
    AST_FLUSH: assert property (conv_start_seq |=> !pop_if.valid ##1 s.busy)
        else $error("read order not restarted");
    AST_OE: assert property (result_bus_oe == $past(rd_act))
        else $error("data enable not following strobes");
    AST_SLEEP: assert property (conv_end_seq |-> s.asleep == $past(auto_sleep_mode))
        else $error("sleep state wrong after conversion");
endmodule : dsadc_ctrl

`default_nettype wire

// *** logic/dsadc_params.svh ***
// timing counts, widths and reset values of the dual simultaneous converter control
`ifndef DSADC_PARAMS_SVH
`define DSADC_PARAMS_SVH

`define DSADC_RES_W 14
`define DSADC_CNT_W 8
`define DSADC_CLK_PERIOD_NS 40
`define DSADC_T_CONV_HS_NS 5200
`define DSADC_T_CONV_AS_NS 10000
`define DSADC_T_ACQ_NS 500
`define DSADC_T_RD_QUIET_NS 400
`define DSADC_CONV_HS_CYC (`DSADC_T_CONV_HS_NS / `DSADC_CLK_PERIOD_NS)
`define DSADC_CONV_AS_CYC (`DSADC_T_CONV_AS_NS / `DSADC_CLK_PERIOD_NS)
`define DSADC_WAKE_CYC (`DSADC_CONV_AS_CYC - `DSADC_CONV_HS_CYC)
`define DSADC_BUF_DEPTH 2
`define DSADC_BIPOLAR_RST 1'b1
`define DSADC_WORD_RST 14'h0000

`endif

// *** logic/dsadc_pkg.sv ***
// shared types of the dual simultaneous converter control
`include "dsadc_params.svh"

package dsadc_pkg;
    typedef logic [`DSADC_RES_W-1:0] dsadc_word_t;
    typedef logic [`DSADC_CNT_W-1:0] dsadc_cnt_t;

    typedef enum logic [2:0] {
        DSADC_TRACK,
        DSADC_WAKE,
        DSADC_CONVERT,
        DSADC_PUSH1,
        DSADC_PUSH2
    } dsadc_state_t;

    typedef struct packed {
        dsadc_state_t st;
        dsadc_cnt_t cnt;
        logic conv_prev;
        logic rd_prev;
        logic pair;
        dsadc_word_t smp1;
        dsadc_word_t smp2;
        logic busy;
        logic hold;
        logic asleep;
        dsadc_word_t dout;
        logic doe;
    } dsadc_ctrl_t;
endpackage : dsadc_pkg

// *** logic/dsadc_stream_if.sv ***
// valid/ready word carrier between the control and its result buffer
`timescale 1ns/100ps
`default_nettype none

interface dsadc_stream_if #(parameter int W = 14);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : dsadc_stream_if

`default_nettype wire

// *** logic/dsadc_buf.sv ***
// two-entry result buffer with flush, valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module dsadc_buf #(
    parameter int W = 14
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic flush,
    dsadc_stream_if.snk wr,
    dsadc_stream_if.src rd
);
    import dsadc_pkg::*;

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } dsadc_buf_state_t;

    dsadc_buf_state_t s;
    dsadc_buf_state_t next_s;
    logic do_push;
    logic do_pop;

    // ready only while a slot is free, so a stalled reader holds off the writer
    assign wr.ready = (s.cnt != 2'h2);
    assign rd.valid = (s.cnt != 2'h0);
    assign rd.data = s.mem[s.rp];
    assign do_push = wr.valid && wr.ready;
    assign do_pop = rd.valid && rd.ready;

    // pointer and count update; flush wins since it marks a new conversion
    always_comb begin
        next_s = s;
        if (flush) begin
            next_s.wp = 1'b0;
            next_s.rp = 1'b0;
            next_s.cnt = 2'h0;
        end else begin
            if (do_push) begin
                next_s.mem[s.wp] = wr.data;
                next_s.wp = ~s.wp;
            end
            if (do_pop) begin
                next_s.rp = ~s.rp;
            end
            next_s.cnt = s.cnt + {1'b0, do_push} - {1'b0, do_pop};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : dsadc_buf

`default_nettype wire

// *** bench/dsadc_host_model.sv ***
// host side model: start strobe and chip-select/read cycles
`timescale 1ns/100ps
`default_nettype none

module dsadc_host_model (
    input wire logic mclk,
    input wire logic busy,
    input wire dsadc_pkg::dsadc_word_t result_bus_o,
    input wire logic result_bus_oe,
    output logic conversion_start_n,
    output logic pair_select,
    output logic cs_n,
    output logic rd_n
);
    import dsadc_pkg::*;

    // strobes idle high so the first falling edge is a clean start
    initial begin
        conversion_start_n = 1'b1;
        pair_select = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
    end

    // one-cycle start pulse after a full acquisition gap
    task automatic start(input logic p);
        repeat (13) @(posedge mclk);
        conversion_start_n <= 1'b0;
        pair_select <= p;
        @(posedge mclk);
        conversion_start_n <= 1'b1;
    endtask : start

    // read cycle; rd_en low keeps read high so only chip-select falls
    task automatic read(input logic rd_en, output dsadc_word_t w, output logic on,
                        output logic off);
        while (busy) @(posedge mclk);
        @(posedge mclk);
        cs_n <= 1'b0;
        rd_n <= ~rd_en;
        @(posedge mclk);
        #1;
        w = result_bus_o;
        on = result_bus_oe;
        @(posedge mclk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        @(posedge mclk);
        #1;
        off = result_bus_oe;
    endtask : read
endmodule : dsadc_host_model

`default_nettype wire

// *** bench/dsadc_ctrl_bench.sv ***
// self-checking bench of the dual converter control
`timescale 1ns/100ps
`default_nettype none

module dsadc_ctrl_bench;
    import dsadc_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic auto_sleep_mode = 1'b0;
    logic conversion_start_n, pair_select, cs_n, rd_n;
    logic busy, hold, asleep, result_bus_oe;
    dsadc_word_t result_bus_o, e1, e2, w;
    dsadc_word_t va1 = 14'h0123, va2 = 14'h3ABC, vb1 = 14'h2000, vb2 = 14'h1FFF;
    logic on, off;
    int mismatches = 0;
    int comparisons = 0;

    // 25 MHz clock
    always #20 mclk = ~mclk;

    dsadc_ctrl u_dut (.mclk(mclk), .nrst(nrst), .conversion_start_n(conversion_start_n),
        .pair_select(pair_select), .auto_sleep_mode(auto_sleep_mode), .cs_n(cs_n),
        .rd_n(rd_n), .pair_a_input_1(va1), .pair_a_input_2(va2), .pair_b_input_1(vb1),
        .pair_b_input_2(vb2), .busy(busy), .hold(hold), .asleep(asleep),
        .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe));

    dsadc_host_model u_host (.mclk(mclk), .busy(busy), .result_bus_o(result_bus_o),
        .result_bus_oe(result_bus_oe), .conversion_start_n(conversion_start_n),
        .pair_select(pair_select), .cs_n(cs_n), .rd_n(rd_n));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // one conversion; inputs move during hold so late values must not leak in
    task automatic convert(input logic p, input int cycles, input logic sleep_after);
        int n;
        n = 0;
        e1 = (p ? vb1 : va1) ^ 14'h2000;
        e2 = (p ? vb2 : va2) ^ 14'h2000;
        u_host.start(p);
        va1 <= ~va1;
        va2 <= ~va2;
        vb1 <= ~vb1;
        vb2 <= ~vb2;
        #1;
        while (busy === 1'b1 && n < 300) begin
            check(16'(hold), 16'(busy));
            if (n == 200) check(16'(asleep), 16'h0000);
            n++;
            @(posedge mclk);
            #1;
        end
        check(16'(n), 16'(cycles));
        check(16'(hold), 16'h0000);
        check(16'(asleep), 16'(sleep_after));
    endtask : convert

    task automatic read_check(input dsadc_word_t exp);
        u_host.read(1'b1, w, on, off);
        check(16'(w), 16'(exp));
        check(16'(on), 16'h0001);
        check(16'(off), 16'h0000);
    endtask : read_check

    task automatic test_reset();
        check(16'({busy, hold, asleep, result_bus_oe}), 16'h0000);
    endtask : test_reset

    // both words in order, then a surplus read repeats the second
    task automatic test_pair_a();
        convert(1'b0, 130, 1'b0);
        read_check(e1);
        read_check(e2);
        read_check(e2);
    endtask : test_pair_a

    // chip-select alone must neither drive the bus nor consume a word
    task automatic test_pair_b_cs_only();
        convert(1'b1, 130, 1'b0);
        u_host.read(1'b0, w, on, off);
        check(16'(on), 16'h0000);
        read_check(e1);
        read_check(e2);
    endtask : test_pair_b_cs_only

    // unread second word is dropped by the next start
    task automatic test_restart();
        convert(1'b0, 130, 1'b0);
        read_check(e1);
        convert(1'b1, 130, 1'b0);
        read_check(e1);
    endtask : test_restart

    // sleep after each end; wake time is charged to the next conversion
    task automatic test_sleep();
        @(posedge mclk);
        auto_sleep_mode <= 1'b1;
        convert(1'b0, 130, 1'b1);
        convert(1'b1, 250, 1'b1);
        auto_sleep_mode <= 1'b0;
        convert(1'b0, 250, 1'b0);
        convert(1'b1, 130, 1'b0);
        read_check(e1);
        read_check(e2);
    endtask : test_sleep

    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        #1;
        test_reset();
        test_pair_a();
        test_pair_b_cs_only();
        test_restart();
        test_sleep();
        finish_test();
    end

    // about 1440 cycles expected; a hang stops well after that
    initial begin
        repeat (6000) @(posedge mclk);
        mismatches++;
        finish_test();
    end
endmodule : dsadc_ctrl_bench

`default_nettype wire
